// File: rtl/bal_alu.sv
// Byte arithmetic and logic datapath of an 8-bit core, with status flags.
// Assumes the decoder presents operands from the register file on the
// core clock and writes back the result when done pulses.
//
// Functional notes
// - Sum and sum with carry, ZCNVH, one cycle
// - Word plus immediate on pair, ZCNVS, two cycles
// - Difference register or immediate, ZCNVH, one cycle
// - Difference with borrow, ZCNVH, one cycle
// - Word minus immediate on pair, ZCNVS, two cycles
// - Conjunction stores AND, only ZNV, one cycle
// - Disjunction stores OR, only ZNV, one cycle
// - Exclusive-or of registers, only ZNV, one cycle
module bal_alu #(
    parameter int IMM_W = 6                     // Word immediate width
) (
    input  wire logic             ref_clk,      // Core clock, 25 MHz
    input  wire logic             arst_n,       // Async reset, active low
    input  wire logic             op_start,     // Take an operation
    input  wire bal_pkg::bal_op_t op_sel,       // Which operation
    input  wire logic [7:0]       dst_val,      // Destination register
    input  wire logic [7:0]       src_val,      // Source register
    input  wire logic [7:0]       imm_val,      // Immediate constant
    input  wire logic [7:0]       pair_lo,      // Pair low register
    input  wire logic [7:0]       pair_hi,      // Pair high register
    output logic                  busy,         // Word op in progress
    output logic                  done,         // Result ready, one cycle
    output logic                  res_word,     // Result is a pair
    output logic [7:0]            res_lo,       // Byte or pair low result
    output logic [7:0]            res_hi,       // Pair high result
    output logic [5:0]            flags         // Status flags
);

    ////////////////////////////////////////////////////////////////////////
    // Parameter check: the word immediate must fit in a byte
    if (IMM_W < 1 || IMM_W > bal_pkg::BAL_DATA_W)
    begin : g_bad_imm
        $error("IMM_W must lie between 1 and 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // All state in one record
    typedef struct packed {
        bal_pkg::bal_state_t st;                // Sequencer state
        bal_pkg::bal_kind_t  wkind;             // Word op: add or subtract
        logic [7:0]          hi_opd;            // Saved pair high byte
        logic                lo_c;              // Carry out of low byte
        logic                lo_z;              // Low byte was zero
        logic                busy;              // Output copy
        logic                done;              // Output copy
        logic                res_word;          // Output copy
        logic [7:0]          res_lo;            // Output copy
        logic [7:0]          res_hi;            // Output copy
        logic [5:0]          flags;             // Output copy
    } bal_state_rec_t;

    localparam bal_state_rec_t REC_RST = '{
        st:       bal_pkg::BAL_ST_IDLE,
        wkind:    bal_pkg::BAL_K_ADD,
        hi_opd:   bal_pkg::BAL_BYTE_RST,
        lo_c:     1'b0,
        lo_z:     1'b0,
        busy:     1'b0,
        done:     1'b0,
        res_word: 1'b0,
        res_lo:   bal_pkg::BAL_BYTE_RST,
        res_hi:   bal_pkg::BAL_BYTE_RST,
        flags:    bal_pkg::BAL_FLAGS_RST
    };

    bal_state_rec_t state;                      // Registered record
    bal_state_rec_t next_state;                 // Next record

    bal_calc_if     cu ();                      // Byte unit bundle

    ////////////////////////////////////////////////////////////////////////
    // Flag update used by every byte operation; S is only touched by
    // word operations, so a byte op leaves it as it stood
    // Conventional flag terms
    function automatic logic [5:0] byte_flags(
        input logic [5:0] old,
        input logic [7:0] y,
        input logic       c,
        input logic       h,
        input logic       v,
        input logic       arith
    );
        logic [5:0] f;
        f                    = old;
        f[bal_pkg::BAL_FLG_Z] = (y == 8'h00);
        f[bal_pkg::BAL_FLG_N] = y[7];
        f[bal_pkg::BAL_FLG_V] = v;
        if (arith)
        begin
            f[bal_pkg::BAL_FLG_C] = c;
            f[bal_pkg::BAL_FLG_H] = h;
        end
        return f;
    endfunction : byte_flags

    ////////////////////////////////////////////////////////////////////////
    // The byte unit does all the arithmetic, for both halves of a word
    bal_byte_unit u_unit (
        .cu (cu.unit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Operand steering and sequencing
    always_comb
    begin
        logic arith;
        logic word_op;
        arith      = 1'b0;
        word_op    = 1'b0;
        next_state = state;
        next_state.done = 1'b0;
        cu.a    = dst_val;
        cu.b    = src_val;
        cu.cin  = 1'b0;
        cu.kind = bal_pkg::BAL_K_ADD;

        unique case (state.st)
            // Ready: requests while busy are never seen here
            bal_pkg::BAL_ST_IDLE:
            begin
                unique case (op_sel)
                    bal_pkg::BAL_OP_SUM:
                    begin
                        arith = 1'b1;
                    end
                    bal_pkg::BAL_OP_SUM_CARRY:
                    begin
                        arith  = 1'b1;
                        cu.cin = state.flags[bal_pkg::BAL_FLG_C];
                    end
                    bal_pkg::BAL_OP_DIFF:
                    begin
                        arith   = 1'b1;
                        cu.kind = bal_pkg::BAL_K_SUB;
                    end
                    bal_pkg::BAL_OP_DIFF_IMM:
                    begin
                        arith   = 1'b1;
                        cu.kind = bal_pkg::BAL_K_SUB;
                        cu.b    = imm_val;
                    end
                    bal_pkg::BAL_OP_DIFF_BORROW:
                    begin
                        arith   = 1'b1;
                        cu.kind = bal_pkg::BAL_K_SUB;
                        cu.cin  = state.flags[bal_pkg::BAL_FLG_C];
                    end
                    bal_pkg::BAL_OP_DIFF_IMM_BOR:
                    begin
                        arith   = 1'b1;
                        cu.kind = bal_pkg::BAL_K_SUB;
                        cu.b    = imm_val;
                        cu.cin  = state.flags[bal_pkg::BAL_FLG_C];
                    end
                    bal_pkg::BAL_OP_WORD_PLUS:
                    begin
                        word_op = 1'b1;
                        cu.a    = pair_lo;
                        cu.b    = {{(8 - IMM_W){1'b0}}, imm_val[IMM_W-1:0]};
                    end
                    bal_pkg::BAL_OP_WORD_MINUS:
                    begin
                        word_op = 1'b1;
                        cu.kind = bal_pkg::BAL_K_SUB;
                        cu.a    = pair_lo;
                        cu.b    = {{(8 - IMM_W){1'b0}}, imm_val[IMM_W-1:0]};
                    end
                    bal_pkg::BAL_OP_CONJ:     cu.kind = bal_pkg::BAL_K_AND;
                    bal_pkg::BAL_OP_CONJ_IMM:
                    begin
                        cu.kind = bal_pkg::BAL_K_AND;
                        cu.b    = imm_val;
                    end
                    bal_pkg::BAL_OP_DISJ:     cu.kind = bal_pkg::BAL_K_OR;
                    bal_pkg::BAL_OP_DISJ_IMM:
                    begin
                        cu.kind = bal_pkg::BAL_K_OR;
                        cu.b    = imm_val;
                    end
                    bal_pkg::BAL_OP_XOR:      cu.kind = bal_pkg::BAL_K_XOR;
                    // Unused codes behave as a sum but are dropped below
                    default:                  cu.kind = bal_pkg::BAL_K_ADD;
                endcase

                if (op_start && word_op)
                begin
                    // Keep the low half and wait one cycle for the high half
                    next_state.st     = bal_pkg::BAL_ST_WORD_HI;
                    next_state.wkind  = cu.kind;
                    next_state.hi_opd = pair_hi;
                    next_state.lo_c   = cu.c_out;
                    next_state.lo_z   = (cu.y == 8'h00);
                    next_state.res_lo = cu.y;
                    next_state.busy   = 1'b1;
                end
                else if (op_start && op_sel <= bal_pkg::BAL_OP_XOR)
                begin
                    // Byte result and flags land together after one cycle
                    next_state.done     = 1'b1;
                    next_state.res_word = 1'b0;
                    next_state.res_lo   = cu.y;
                    next_state.res_hi   = bal_pkg::BAL_BYTE_RST;
                    next_state.flags    = byte_flags(state.flags, cu.y,
                        cu.c_out, cu.h_out, cu.v_out, arith);
                end
            end

            // High byte: ripple the saved carry into the pair high byte
            bal_pkg::BAL_ST_WORD_HI:
            begin
                cu.a    = state.hi_opd;
                cu.b    = 8'h00;
                cu.cin  = state.lo_c;
                cu.kind = state.wkind;
                next_state.st       = bal_pkg::BAL_ST_IDLE;
                next_state.busy     = 1'b0;
                next_state.done     = 1'b1;
                next_state.res_word = 1'b1;
                next_state.res_hi   = cu.y;
                // Word flags from the whole 16-bit result
                next_state.flags[bal_pkg::BAL_FLG_Z] =
                    state.lo_z & (cu.y == 8'h00);
                next_state.flags[bal_pkg::BAL_FLG_N] = cu.y[7];
                next_state.flags[bal_pkg::BAL_FLG_V] = cu.v_out;
                next_state.flags[bal_pkg::BAL_FLG_C] = cu.c_out;
                next_state.flags[bal_pkg::BAL_FLG_S] =
                    cu.y[7] ^ cu.v_out;
            end

            // Illegal code: recover to idle
            default:
            begin
                next_state = REC_RST;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            state <= REC_RST;
        else
            state <= next_state;
    end

    // Outputs straight from the record
    assign busy     = state.busy;
    assign done     = state.done;
    assign res_word = state.res_word;
    assign res_lo   = state.res_lo;
    assign res_hi   = state.res_hi;
    assign flags    = state.flags;

endmodule : bal_alu

// File: rtl/bal_pkg.sv
// Shared constants and types of the byte arithmetic and logic datapath.
// Assumes one core clock; operand values come from the register file
// on the same clock, so no input needs synchronising.
package bal_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int BAL_DATA_W = 8;              // Byte width
    localparam int BAL_FLAG_W = 6;              // Status flags kept here

    ////////////////////////////////////////////////////////////////////////
    // Status flag positions inside the flag vector
    localparam int BAL_FLG_C = 0;               // Carry or borrow out
    localparam int BAL_FLG_Z = 1;               // Result zero
    localparam int BAL_FLG_N = 2;               // Result negative
    localparam int BAL_FLG_V = 3;               // Two's complement overflow
    localparam int BAL_FLG_S = 4;               // Sign, N xor V
    localparam int BAL_FLG_H = 5;               // Carry out of bit three

    // Value after reset
    localparam logic [5:0] BAL_FLAGS_RST = 6'h00;   // All flags clear
    localparam logic [7:0] BAL_BYTE_RST  = 8'h00;   // Result bytes clear

    ////////////////////////////////////////////////////////////////////////
    // Cycle counts of each class of operation
    localparam int BAL_BYTE_CYCLES = 1;         // Byte operations
    localparam int BAL_WORD_CYCLES = 2;         // Word immediate operations

    ////////////////////////////////////////////////////////////////////////
    // Operation select presented by the decoder
    typedef enum logic [3:0] {
        BAL_OP_SUM          = 4'h0,             // Dest + source
        BAL_OP_SUM_CARRY    = 4'h1,             // Dest + source + C
        BAL_OP_WORD_PLUS    = 4'h2,             // Pair + immediate
        BAL_OP_DIFF         = 4'h3,             // Dest - source
        BAL_OP_DIFF_IMM     = 4'h4,             // Dest - immediate
        BAL_OP_DIFF_BORROW  = 4'h5,             // Dest - source - C
        BAL_OP_DIFF_IMM_BOR = 4'h6,             // Dest - immediate - C
        BAL_OP_WORD_MINUS   = 4'h7,             // Pair - immediate
        BAL_OP_CONJ         = 4'h8,             // Dest and source
        BAL_OP_CONJ_IMM     = 4'h9,             // Dest and immediate
        BAL_OP_DISJ         = 4'ha,             // Dest or source
        BAL_OP_DISJ_IMM     = 4'hb,             // Dest or immediate
        BAL_OP_XOR          = 4'hc              // Dest xor source
    } bal_op_t;

    // Kind of work asked of the byte unit
    typedef enum logic [2:0] {
        BAL_K_ADD = 3'h0,                       // Add with carry in
        BAL_K_SUB = 3'h1,                       // Subtract with borrow in
        BAL_K_AND = 3'h2,                       // Bitwise and
        BAL_K_OR  = 3'h3,                       // Bitwise or
        BAL_K_XOR = 3'h4                        // Bitwise exclusive or
    } bal_kind_t;

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        BAL_ST_IDLE    = 2'b01,                 // Ready for an operation
        BAL_ST_WORD_HI = 2'b10                  // Second cycle of a word op
    } bal_state_t;

endpackage : bal_pkg

// File: rtl/bal_calc_if.sv
// Operand and result bundle between the sequencer and the byte unit.
// Purely combinational; both ends live on the core clock.
interface bal_calc_if;
    logic [7:0]         a;                      // First operand
    logic [7:0]         b;                      // Second operand
    logic               cin;                    // Carry or borrow in
    bal_pkg::bal_kind_t kind;                   // Work to do
    logic [7:0]         y;                      // Result byte
    logic               c_out;                  // Carry or borrow out
    logic               h_out;                  // Half carry out
    logic               v_out;                  // Signed overflow

    // Sequencer side
    modport core (output a, b, cin, kind, input y, c_out, h_out, v_out);
    // Arithmetic side
    modport unit (input a, b, cin, kind, output y, c_out, h_out, v_out);
endinterface : bal_calc_if

// File: rtl/bal_byte_unit.sv
// Byte-wide adder, subtractor and bitwise unit with raw flag terms.
// Assumes the caller folds Z and N from the result and keeps the flags.
module bal_byte_unit (
    bal_calc_if.unit cu                         // Operands in, result out
);

    ////////////////////////////////////////////////////////////////////////
    // Result and carry terms; logic kinds report no carry or overflow
    always_comb
    begin
        logic [8:0] wide;
        wide     = 9'h000;
        cu.y     = 8'h00;
        cu.c_out = 1'b0;
        cu.h_out = 1'b0;
        cu.v_out = 1'b0;
        unique case (cu.kind)
            // Sum with carry in
            bal_pkg::BAL_K_ADD:
            begin
                wide     = {1'b0, cu.a} + {1'b0, cu.b} + {8'h00, cu.cin};
                cu.y     = wide[7:0];
                cu.c_out = wide[8];
                cu.h_out = (cu.a[3] & cu.b[3]) | (cu.b[3] & ~wide[3])
                         | (~wide[3] & cu.a[3]);
                cu.v_out = (cu.a[7] & cu.b[7] & ~wide[7])
                         | (~cu.a[7] & ~cu.b[7] & wide[7]);
            end
            // Difference with borrow in; bit 8 of the wrap is the borrow
            bal_pkg::BAL_K_SUB:
            begin
                wide     = {1'b0, cu.a} - {1'b0, cu.b} - {8'h00, cu.cin};
                cu.y     = wide[7:0];
                cu.c_out = wide[8];
                cu.h_out = (~cu.a[3] & cu.b[3]) | (cu.b[3] & wide[3])
                         | (wide[3] & ~cu.a[3]);
                cu.v_out = (cu.a[7] & ~cu.b[7] & ~wide[7])
                         | (~cu.a[7] & cu.b[7] & wide[7]);
            end
            bal_pkg::BAL_K_AND: cu.y = cu.a & cu.b;   // Conjunction
            bal_pkg::BAL_K_OR:  cu.y = cu.a | cu.b;   // Disjunction
            bal_pkg::BAL_K_XOR: cu.y = cu.a ^ cu.b;   // Exclusive or
            // Unused kind codes give zero
            default:            cu.y = 8'h00;
        endcase
    end

endmodule : bal_byte_unit

// File: verification/bal_alu_checker.sv
// Concurrent checks on the ports of the byte arithmetic datapath.
// Assumes one clock domain and the async active-low reset of the core.
module bal_alu_checker #(
    parameter int IMM_W = 6                     // Word immediate width
) (
    input wire logic             ref_clk,       // Core clock
    input wire logic             arst_n,        // Async reset, active low
    input wire logic             op_start,      // Request
    input wire bal_pkg::bal_op_t op_sel,        // Operation code
    input wire logic [7:0]       dst_val,       // Destination operand
    input wire logic [7:0]       src_val,       // Source operand
    input wire logic [7:0]       imm_val,       // Immediate
    input wire logic [7:0]       pair_lo,       // Pair low
    input wire logic [7:0]       pair_hi,       // Pair high
    input wire logic             busy,          // Word op running
    input wire logic             done,          // Result pulse
    input wire logic             res_word,      // Pair result
    input wire logic [7:0]       res_lo,        // Low result
    input wire logic [7:0]       res_hi,        // High result
    input wire logic [5:0]       flags          // Status flags
);
    timeunit 1ns;
    timeprecision 1ps;
    // Only the low IMM_W bits of the immediate reach a word op
    localparam logic [7:0] MASK = 8'((9'h001 << IMM_W) - 9'h001);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////
    // Steps of a request and of a word op
    sequence s_take(bal_pkg::bal_op_t op);
        op_start && !busy && op_sel == op;
    endsequence
    sequence s_word_end;
        busy && !done ##1 done && !busy && res_word;
    endsequence

    property p_sum;
        s_take(bal_pkg::BAL_OP_SUM) |=> done && !res_word && res_lo == 8'($past(dst_val) + $past(src_val));
    endproperty
    a_sum: assert property (p_sum) else $error("sum wrong");
    property p_wplus;
        s_take(bal_pkg::BAL_OP_WORD_PLUS) |=> s_word_end;
    endproperty
    a_wplus: assert property (p_wplus) else $error("word add timing wrong");
    property p_diff;
        s_take(bal_pkg::BAL_OP_DIFF) |=> done && res_lo == 8'($past(dst_val) - $past(src_val));
    endproperty
    a_diff: assert property (p_diff) else $error("difference wrong");
    property p_borrow;
        s_take(bal_pkg::BAL_OP_DIFF_BORROW) |=> done && res_lo == 8'($past(dst_val) - $past(src_val) - $past(flags[bal_pkg::BAL_FLG_C]));
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow wrong");
    property p_wminus;
        s_take(bal_pkg::BAL_OP_WORD_MINUS) |=> s_word_end and (##1 {res_hi, res_lo} == ({$past(pair_hi, 2), $past(pair_lo, 2)} - {8'h00, $past(imm_val, 2) & MASK}));
    endproperty
    a_wminus: assert property (p_wminus) else $error("word subtract wrong");
    property p_conj;
        s_take(bal_pkg::BAL_OP_CONJ) |=> done && res_lo == ($past(dst_val) & $past(src_val)) && !flags[bal_pkg::BAL_FLG_V] && $stable(flags[bal_pkg::BAL_FLG_C]) && $stable(flags[bal_pkg::BAL_FLG_H]);
    endproperty
    a_conj: assert property (p_conj) else $error("and wrong");
    property p_disj;
        s_take(bal_pkg::BAL_OP_DISJ_IMM) |=> done && res_lo == ($past(dst_val) | $past(imm_val)) && !flags[bal_pkg::BAL_FLG_V];
    endproperty
    a_disj: assert property (p_disj) else $error("or wrong");
    property p_xor;
        s_take(bal_pkg::BAL_OP_XOR) |=> done && res_lo == ($past(dst_val) ^ $past(src_val)) && !flags[bal_pkg::BAL_FLG_V];
    endproperty
    a_xor: assert property (p_xor) else $error("xor wrong");
    property p_zn;
        done |-> flags[bal_pkg::BAL_FLG_Z] == (res_word ? {res_hi, res_lo} == 16'h0000 : res_lo == 8'h00) && flags[bal_pkg::BAL_FLG_N] == (res_word ? res_hi[7] : res_lo[7]) && (!res_word || flags[bal_pkg::BAL_FLG_S] == (flags[bal_pkg::BAL_FLG_N] ^ flags[bal_pkg::BAL_FLG_V]));
    endproperty
    a_zn: assert property (p_zn) else $error("zero or sign flag wrong");
endmodule : bal_alu_checker

// File: verification/bal_dec_model.sv
// Decoder and register file stand-in that presents one operation.
// Assumes the bench calls issue only while the datapath is idle.
module bal_dec_model (
    input  wire logic       ref_clk,            // Core clock
    output bal_pkg::bal_op_t op_sel,            // Operation code
    output logic            op_start,           // Request
    output logic [7:0]      dst_val,            // Destination operand
    output logic [7:0]      src_val,            // Source operand
    output logic [7:0]      imm_val,            // Immediate
    output logic [7:0]      pair_lo,            // Pair low
    output logic [7:0]      pair_hi             // Pair high
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {op_start, dst_val, src_val, imm_val, pair_lo, pair_hi} = '0;
        op_sel = bal_pkg::BAL_OP_SUM;
    end

    // Drive at a falling edge, hold one taking edge, then release the
    // operands to their inverse so stale values never match
    task automatic issue(input logic [3:0] op, input logic [7:0] d, s, i, lo, hi);
        @(negedge ref_clk);
        op_start = 1'b1;
        op_sel   = bal_pkg::bal_op_t'(op);
        {dst_val, src_val, imm_val, pair_lo, pair_hi} = {d, s, i, lo, hi};
        @(negedge ref_clk);
        op_start = 1'b0;
        {dst_val, src_val, imm_val, pair_lo, pair_hi} = ~{d, s, i, lo, hi};
    endtask : issue
endmodule : bal_dec_model

// File: verification/tb_byte_alu_add_sub_logic.sv
// Self-checking bench of the byte arithmetic datapath.
// Assumes the package, interface and design files are compiled first.
module tb_byte_alu_add_sub_logic;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int         IMM_W = 6;                        // Word immediate width
    localparam logic [7:0] MASK  = 8'((9'h001 << IMM_W) - 9'h001);
    logic             ref_clk = 1'b0;                        // Core clock
    logic             arst_n  = 1'b0;                        // Reset
    logic             op_start, busy, done, res_word;        // Handshake
    bal_pkg::bal_op_t op_sel;                                // Operation
    logic [7:0]       dst_val, src_val, imm_val, pair_lo, pair_hi, res_lo, res_hi;
    logic [5:0]       flags;                                 // Status flags
    logic [5:0]       ef = 6'h00;                            // Expected flags held
    int               err_count = 0;                         // Mismatches
    int               samples_checked = 0;                   // Comparisons

    always #20 ref_clk = ~ref_clk;

    bal_dec_model u_dec (.ref_clk, .op_sel, .op_start, .dst_val, .src_val, .imm_val,
        .pair_lo, .pair_hi);
    bal_alu #(.IMM_W(IMM_W)) u_dut (.ref_clk, .arst_n, .op_start, .op_sel, .dst_val,
        .src_val, .imm_val, .pair_lo, .pair_hi, .busy, .done, .res_word, .res_lo,
        .res_hi, .flags);

    ////////////////////////////////////////////////////////////////////////
    // Expected {res_word, res_hi, res_lo, flags}; flags C0 Z1 N2 V3 S4 H5
    function automatic logic [22:0] model(input logic [3:0] op,
        input logic [7:0] d, s, i, lo, hi, input logic [5:0] f);
        logic [8:0]  r;
        logic [4:0]  h;
        logic [16:0] w;
        logic [7:0]  b;
        logic        cin;
        logic [5:0]  n;
        n   = f;
        cin = (op inside {4'h1, 4'h5, 4'h6}) ? f[0] : 1'b0;
        b   = (op inside {4'h4, 4'h6, 4'h9, 4'hb}) ? i : s;
        if (op == 4'h2 || op == 4'h7)
        begin
            // Word ops: H kept, S from N and V
            w    = (op == 4'h2) ? {1'b0, hi, lo} + {9'h000, i & MASK}
                                : {1'b0, hi, lo} - {9'h000, i & MASK};
            n[0] = w[16];
            n[3] = (op == 4'h2) ? (!hi[7] && w[15]) : (hi[7] && !w[15]);
            n[1] = w[15:0] == 16'h0000;
            n[2] = w[15];
            n[4] = n[2] ^ n[3];
            return {1'b1, w[15:0], n};
        end
        if (op <= 4'h1)
        begin
            r    = d + b + cin;
            h    = d[3:0] + b[3:0] + cin;
            n[3] = d[7] == b[7] && r[7] != d[7];
        end
        else if (op <= 4'h6)
        begin
            r    = {1'b0, d} - b - cin;
            h    = {1'b0, d[3:0]} - b[3:0] - cin;
            n[3] = d[7] != b[7] && r[7] != d[7];
        end
        else
        begin
            // Logic ops leave C and H, clear V
            r    = {f[0], (op <= 4'h9) ? d & b : (op <= 4'hb) ? d | b : d ^ b};
            h    = {f[5], 4'h0};
            n[3] = 1'b0;
        end
        n[0] = r[8];
        n[5] = h[4];
        n[1] = r[7:0] == 8'h00;
        n[2] = r[7];
        return {1'b0, 8'h00, r[7:0], n};
    endfunction : model

    task automatic chk(input logic [22:0] got, exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Issue one op, wait bounded for done, check latency and result
    task automatic run_op(input logic [3:0] op, input logic [7:0] d, s, i, lo, hi);
        logic [22:0] e;
        int          n;
        e = model(op, d, s, i, lo, hi, ef);
        n = 1;
        u_dec.issue(op, d, s, i, lo, hi);
        while (done !== 1'b1 && n < 4)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk(23'(n), (op == 4'h2 || op == 4'h7) ? 23'h2 : 23'h1, "latency");
        chk({res_word, res_hi, res_lo, flags}, e, "result");
        ef = e[5:0];
    endtask : run_op

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    initial
    begin
        #(40 * 8000);
        err_count++;
        stop_test();
    end

    initial
    begin
        void'($urandom(58580));
        repeat (5) @(negedge ref_clk);
        arst_n = 1'b1;
        run_op(4'h0, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00);
        run_op(4'h1, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00);
        run_op(4'h2, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff);
        run_op(4'h2, 8'h00, 8'h00, 8'h01, 8'hff, 8'h7f);
        run_op(4'h3, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00);
        run_op(4'h4, 8'h10, 8'h00, 8'h01, 8'h00, 8'h00);
        run_op(4'h3, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00);
        run_op(4'h5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        run_op(4'h6, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00);
        run_op(4'h7, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00);
        run_op(4'h7, 8'h00, 8'h00, 8'h01, 8'h00, 8'h80);
        run_op(4'h8, 8'hf0, 8'h0f, 8'h00, 8'h00, 8'h00);
        run_op(4'h9, 8'hc3, 8'h00, 8'h81, 8'h00, 8'h00);
        run_op(4'ha, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        run_op(4'hb, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00);
        run_op(4'hc, 8'h5a, 8'h5a, 8'h00, 8'h00, 8'h00);
        $display("test corners done");
        repeat (300)
            run_op(4'($urandom_range(12)), 8'($urandom), 8'($urandom), 8'($urandom),
                   8'($urandom), 8'($urandom));
        $display("test random done");
        // Reset in the middle of a word op must clear the held carry
        u_dec.issue(4'h2, 8'h00, 8'h00, 8'h3f, 8'hff, 8'hff);
        arst_n = 1'b0;
        ef     = 6'h00;
        @(negedge ref_clk);
        arst_n = 1'b1;
        run_op(4'h1, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00);
        $display("test reset done");
        stop_test();
    end
endmodule : tb_byte_alu_add_sub_logic

bind bal_alu bal_alu_checker #(.IMM_W(IMM_W)) u_chk (.ref_clk, .arst_n, .op_start, .op_sel,
    .dst_val, .src_val, .imm_val, .pair_lo, .pair_hi, .busy, .done, .res_word, .res_lo,
    .res_hi, .flags);
